// file: dpos_defs.svh
// Offsets, field positions, reset values and codes for the dual port ownership block
`ifndef DPOS_DEFS_SVH
`define DPOS_DEFS_SVH

`define DPOS_ADDR_BUS_STATUS  8'h00
`define DPOS_ADDR_STATUS_WORD 8'h04
`define DPOS_ADDR_STATUS_CML  8'h08
`define DPOS_ADDR_LIVE_STATE  8'h0c
`define DPOS_ADDR_OC_RESP     8'h10
`define DPOS_ADDR_OT_RESP     8'h14
`define DPOS_ADDR_CTRL        8'h18
`define DPOS_ADDR_OPERATION   8'h1c

`define DPOS_BS_CTRL0_BIT     0
`define DPOS_BS_CTRL1_BIT     4
`define DPOS_FLAG_REJECT      3'h6
`define DPOS_FLAG_TAKE_OWN    3'h3
`define DPOS_FLAG_TAKE_OTHER  3'h2

`define DPOS_SW_CML_BIT       1
`define DPOS_SW_FAULT_LSB     2
`define DPOS_CML_INVALID_BIT  7
`define DPOS_NFAULT           10
`define DPOS_FAULT_ALERT_MASK 10'h2ff

`define DPOS_CTRL_CMD_EN_BIT  0
`define DPOS_CTRL_CLEAR_BIT   1

`define DPOS_RST_CTRL         8'h01
`define DPOS_RST_OC_RESP      8'h00
`define DPOS_RST_OT_RESP      8'h00
`define DPOS_RST_OPERATION    8'h80

`define DPOS_RESP_OKAY        2'h0
`define DPOS_RESP_SLVERR      2'h2

`endif

// file: dpos_pkg.sv
// Types shared by the dual port ownership block
package dpos_pkg;

	typedef enum logic {
		DPOS_OWN_P0 = 1'b0,
		DPOS_OWN_P1 = 1'b1
	} dpos_owner_t;

	typedef enum logic [2:0] {
		DPOS_CMD_READ     = 3'b000,
		DPOS_CMD_OC_RESP  = 3'b001,
		DPOS_CMD_OT_RESP  = 3'b010,
		DPOS_CMD_OPER     = 3'b011,
		DPOS_CMD_CLEAR    = 3'b100,
		DPOS_CMD_TAKEOVER = 3'b101,
		DPOS_CMD_INVALID  = 3'b110,
		DPOS_CMD_SPARE    = 3'b111
	} dpos_cmd_t;

endpackage

// file: dpos_port_sampler.sv
// Serial port command sampler: synchronises a port's lines and emits one event per serial clock rise with req high
`timescale 1ns/1ps
module dpos_port_sampler #(
	parameter int KW = 3,
	parameter int DW = 8
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          ce,
	// Port lines from the serial engine
	input  wire logic          scl,
	input  wire logic          req,
	input  wire logic [KW-1:0] kind,
	input  wire logic [DW-1:0] data,
	// Event towards the core
	output logic               evt,
	output logic      [KW-1:0] evt_kind,
	output logic      [DW-1:0] evt_data
);
	logic [KW+DW+1:0] sync_m_q;
	logic [KW+DW+1:0] sync_s_q;
	logic             scl_d_q;
	logic             fire;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_m_q <= '0;
			sync_s_q <= '0;
			scl_d_q  <= 1'b0;
		end else if (ce) begin
			sync_m_q <= {scl, req, kind, data};
			sync_s_q <= sync_m_q;
			scl_d_q  <= sync_s_q[KW+DW+1];
		end
	end

	assign fire = sync_s_q[KW+DW+1] & ~scl_d_q & sync_s_q[KW+DW];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			evt      <= 1'b0;
			evt_kind <= '0;
			evt_data <= '0;
		end else if (ce) begin
			evt <= fire;
			if (fire) begin
				evt_kind <= sync_s_q[KW+DW-1:DW];
				evt_data <= sync_s_q[DW-1:0];
			end
		end
	end
endmodule // dpos_port_sampler

// file: dpos_sticky_bank.sv
// Bank of sticky flags where a set in the clearing cycle wins
`timescale 1ns/1ps
module dpos_sticky_bank #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	// Set and clear per bit
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	// Held flags
	output logic      [W-1:0] q
);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else if (ce) begin
			q <= (q & ~clr) | set;
		end
	end
endmodule // dpos_sticky_bank

// file: dpos_top.sv
// Ownership, rejection and latched status reporting for two redundant serial management ports
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "dpos_defs.svh"
module dpos_top
	import dpos_pkg::*;
#(
	parameter int NLIVE = 4,
	parameter int NFIN  = 9
) (
	// Clock, reset and enable
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	// Serial port 0 command lines
	input  wire logic             p0_scl,
	input  wire logic             p0_req,
	input  wire logic [2:0]       p0_kind,
	input  wire logic [7:0]       p0_data,
	// Serial port 1 command lines
	input  wire logic             p1_scl,
	input  wire logic             p1_req,
	input  wire logic [2:0]       p1_kind,
	input  wire logic [7:0]       p1_data,
	// Unit condition inputs
	input  wire logic [NFIN-1:0]  fault_in,
	input  wire logic [NLIVE-1:0] live_in,
	// Alert outputs, active low
	output logic                  alert0_n,
	output logic                  alert1_n,
	// Command register outputs towards the unit
	output logic      [7:0]       oc_resp,
	output logic      [7:0]       ot_resp,
	output logic      [7:0]       operation,
	// AXI4-Lite write address
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [7:0]       s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	// AXI4-Lite write response
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	output logic      [1:0]       s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	input  wire logic [7:0]       s_axi_araddr,
	// AXI4-Lite read data
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	output logic      [31:0]      s_axi_rdata,
	output logic      [1:0]       s_axi_rresp
);

	// Port events
	logic                   evt      [2];
	logic [2:0]             evt_kind [2];
	logic [7:0]             evt_data [2];

	// Ownership and flags
	dpos_owner_t            own_q;
	logic [2:0]             flags    [2];
	logic [2:0]             flag_set [2];
	logic [2:0]             flag_clr [2];
	logic [1:0]             cml_q;
	logic [1:0]             cml_set;
	logic [1:0]             cml_clr;

	// Per port decoded commands
	logic [1:0]             in_ctrl;
	logic [1:0]             take;
	logic [1:0]             rej;
	logic [1:0]             clr;
	logic [1:0]             bad;
	logic [1:0]             wr;

	// Unit condition sampling
	logic [NFIN-1:0]        fin_m_q;
	logic [NFIN-1:0]        fin_s_q;
	logic [NLIVE-1:0]       live_m_q;
	logic [NLIVE-1:0]       live_s_q;
	logic [`DPOS_NFAULT-1:0] fault_set;
	logic [`DPOS_NFAULT-1:0] fault_clr;
	logic [`DPOS_NFAULT-1:0] fault_q;
	logic                   unit_alert;
	logic                   ctrl_clear;

	// Software view
	logic [7:0]             ctrl_q;
	logic                   sw_clear_q;
	logic [7:0]             bus_status;
	logic [15:0]            status_word;
	logic [7:0]             status_cml;
	logic                   cmd_en;

	// Bus slave
	logic                   wr_go;
	logic                   rd_go;
	logic                   wr_hit;
	logic                   rd_hit;
	logic [31:0]            rd_val;

	// Samplers for the two serial ports
	dpos_port_sampler #(
		.KW (3),
		.DW (8)
	) u_samp0 (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.scl      (p0_scl),
		.req      (p0_req),
		.kind     (p0_kind),
		.data     (p0_data),
		.evt      (evt[0]),
		.evt_kind (evt_kind[0]),
		.evt_data (evt_data[0])
	);

	dpos_port_sampler #(
		.KW (3),
		.DW (8)
	) u_samp1 (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.scl      (p1_scl),
		.req      (p1_req),
		.kind     (p1_kind),
		.data     (p1_data),
		.evt      (evt[1]),
		.evt_kind (evt_kind[1]),
		.evt_data (evt_data[1])
	);

	assign cmd_en = ctrl_q[`DPOS_CTRL_CMD_EN_BIT];

	// Decode each port's command against ownership
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			in_ctrl[p] = (own_q == dpos_owner_t'(p[0]));
			take[p]    = 1'b0;
			rej[p]     = 1'b0;
			clr[p]     = 1'b0;
			bad[p]     = 1'b0;
			wr[p]      = 1'b0;
			if (evt[p] && cmd_en) begin
				case (dpos_cmd_t'(evt_kind[p]))
					DPOS_CMD_READ: begin
					end
					DPOS_CMD_CLEAR: begin
						clr[p] = 1'b1;
					end
					DPOS_CMD_TAKEOVER: begin
						take[p] = ~in_ctrl[p];
					end
					DPOS_CMD_INVALID, DPOS_CMD_SPARE: begin
						rej[p] = ~in_ctrl[p];
						bad[p] = in_ctrl[p];
					end
					default: begin
						rej[p] = ~in_ctrl[p];
						wr[p]  = in_ctrl[p];
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			own_q <= DPOS_OWN_P0;
		end else if (ce) begin
			if (take[0]) begin
				own_q <= DPOS_OWN_P0;
			end else if (take[1]) begin
				own_q <= DPOS_OWN_P1;
			end
		end
	end

	always_comb begin
		for (int p = 0; p < 2; p++) begin
			flag_set[p] = 3'h0;
			if (rej[p]) begin
				flag_set[p] = flag_set[p] | `DPOS_FLAG_REJECT;
			end
			if (take[p]) begin
				flag_set[p] = flag_set[p] | `DPOS_FLAG_TAKE_OWN;
			end
			if (take[1-p]) begin
				flag_set[p] = flag_set[p] | `DPOS_FLAG_TAKE_OTHER;
			end
			flag_clr[p] = {3{clr[p]}};
		end
	end

	dpos_sticky_bank #(
		.W (3)
	) u_flags0 (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.set (flag_set[0]),
		.clr (flag_clr[0]),
		.q   (flags[0])
	);

	dpos_sticky_bank #(
		.W (3)
	) u_flags1 (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.set (flag_set[1]),
		.clr (flag_clr[1]),
		.q   (flags[1])
	);

	assign cml_set = bad;
	assign cml_clr = clr;

	dpos_sticky_bank #(
		.W (2)
	) u_cml (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.set (cml_set),
		.clr (cml_clr),
		.q   (cml_q)
	);

	// Unit condition synchronisers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fin_m_q  <= '0;
			fin_s_q  <= '0;
			// Output taken as on, so leaving reset latches no shutdown
			live_m_q <= {{(NLIVE-1){1'b0}}, 1'b1};
			live_s_q <= {{(NLIVE-1){1'b0}}, 1'b1};
		end else if (ce) begin
			fin_m_q  <= fault_in;
			fin_s_q  <= fin_m_q;
			live_m_q <= live_in;
			live_s_q <= live_m_q;
		end
	end

	assign fault_set = {fin_s_q[8:7], ~live_s_q[0], fin_s_q[6:0]};

	// owner clear wipes
	// Only the owner or software wipes the unit faults
	assign ctrl_clear = (clr[0] & in_ctrl[0]) | (clr[1] & in_ctrl[1]) | sw_clear_q;
	assign fault_clr  = {`DPOS_NFAULT{ctrl_clear}};

	dpos_sticky_bank #(
		.W (`DPOS_NFAULT)
	) u_faults (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.set (fault_set),
		.clr (fault_clr),
		.q   (fault_q)
	);

	assign unit_alert = |(fault_q & `DPOS_FAULT_ALERT_MASK);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			oc_resp   <= `DPOS_RST_OC_RESP;
			ot_resp   <= `DPOS_RST_OT_RESP;
			operation <= `DPOS_RST_OPERATION;
		end else if (ce) begin
			for (int p = 0; p < 2; p++) begin
				if (wr[p]) begin
					case (dpos_cmd_t'(evt_kind[p]))
						DPOS_CMD_OC_RESP: oc_resp   <= evt_data[p];
						DPOS_CMD_OT_RESP: ot_resp   <= evt_data[p];
						DPOS_CMD_OPER:    operation <= evt_data[p];
						default: begin
						end
					endcase
				end
			end
		end
	end

	assign bus_status = {flags[1], in_ctrl[1], flags[0], in_ctrl[0]};

	always_comb begin
		status_word = 16'h0000;
		status_word[`DPOS_SW_CML_BIT] = |cml_q;
		status_word[`DPOS_SW_FAULT_LSB +: `DPOS_NFAULT] = fault_q;
		status_cml = 8'h00;
		status_cml[`DPOS_CML_INVALID_BIT] = |cml_q;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alert0_n <= 1'b1;
			alert1_n <= 1'b1;
		end else if (ce) begin
			alert0_n <= ~(((|flags[0]) & ~in_ctrl[0]) | unit_alert | cml_q[0]);
			alert1_n <= ~(((|flags[1]) & ~in_ctrl[1]) | unit_alert | cml_q[1]);
		end
	end

	// Write path: address and data are taken together
	assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ce;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign wr_hit        = (s_axi_awaddr == `DPOS_ADDR_CTRL);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q     <= `DPOS_RST_CTRL;
			sw_clear_q <= 1'b0;
		end else if (ce) begin
			sw_clear_q <= 1'b0;
			if (wr_go && wr_hit && s_axi_wstrb[0]) begin
				ctrl_q     <= {6'h00, 1'b0, s_axi_wdata[`DPOS_CTRL_CMD_EN_BIT]};
				sw_clear_q <= s_axi_wdata[`DPOS_CTRL_CLEAR_BIT];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `DPOS_RESP_OKAY;
		end else if (ce) begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_hit || rd_decode(s_axi_awaddr)) ? `DPOS_RESP_OKAY : `DPOS_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Mapped addresses
	function automatic logic rd_decode(input logic [7:0] a);
		case (a)
			`DPOS_ADDR_BUS_STATUS, `DPOS_ADDR_STATUS_WORD, `DPOS_ADDR_STATUS_CML, `DPOS_ADDR_LIVE_STATE,
			`DPOS_ADDR_OC_RESP, `DPOS_ADDR_OT_RESP, `DPOS_ADDR_CTRL, `DPOS_ADDR_OPERATION: rd_decode = 1'b1;
			default: rd_decode = 1'b0;
		endcase
	endfunction

	// Read path
	assign rd_go         = s_axi_arvalid & ~s_axi_rvalid & ce;
	assign s_axi_arready = rd_go;
	assign rd_hit        = rd_decode(s_axi_araddr);

	always_comb begin
		case (s_axi_araddr)
			`DPOS_ADDR_BUS_STATUS:  rd_val = {24'h000000, bus_status};
			`DPOS_ADDR_STATUS_WORD: rd_val = {16'h0000, status_word};
			`DPOS_ADDR_STATUS_CML:  rd_val = {24'h000000, status_cml};
			`DPOS_ADDR_LIVE_STATE:  rd_val = {{(32-NLIVE){1'b0}}, live_s_q};
			`DPOS_ADDR_OC_RESP:     rd_val = {24'h000000, oc_resp};
			`DPOS_ADDR_OT_RESP:     rd_val = {24'h000000, ot_resp};
			`DPOS_ADDR_CTRL:        rd_val = {24'h000000, ctrl_q};
			`DPOS_ADDR_OPERATION:   rd_val = {24'h000000, operation};
			default:                rd_val = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `DPOS_RESP_OKAY;
		end else if (ce) begin
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= rd_hit ? `DPOS_RESP_OKAY : `DPOS_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // dpos_top

// file: dpos_props.sv
// Port level checks for the ownership and status block
`timescale 1ns/1ps
`include "dpos_defs.svh"
module dpos_props #(
	parameter int NLIVE = 4,
	parameter int NFIN  = 9
) (
	// Clock and reset
	input wire logic             clk,
	input wire logic             rst,
	// Causes
	input wire logic             p0_req,
	input wire logic             p1_req,
	input wire logic [NFIN-1:0]  fault_in,
	input wire logic [NLIVE-1:0] live_in,
	input wire logic             s_axi_wvalid,
	input wire logic             s_axi_awvalid,
	input wire logic             s_axi_awready,
	input wire logic [7:0]       s_axi_awaddr,
	input wire logic             s_axi_arvalid,
	input wire logic             s_axi_arready,
	input wire logic [7:0]       s_axi_araddr,
	// Outputs
	input wire logic             alert0_n,
	input wire logic             alert1_n,
	input wire logic [7:0]       oc_resp,
	input wire logic [7:0]       ot_resp,
	input wire logic [7:0]       operation,
	input wire logic             s_axi_bvalid,
	input wire logic [1:0]       s_axi_bresp,
	input wire logic             s_axi_rvalid,
	input wire logic [1:0]       s_axi_rresp
);
	logic [3:0] qreq_q, qwr_q, qflt_q, qoff_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Cycles since the last port request, bus write and fault, and cycles the output has been off
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			qreq_q <= 4'hf;
			qwr_q  <= 4'hf;
			qflt_q <= 4'hf;
			qoff_q <= 4'h0;
		end else begin
			qreq_q <= (p0_req || p1_req) ? 4'h0 : qreq_q + {3'h0, qreq_q != 4'hf};
			qwr_q  <= s_axi_wvalid ? 4'h0 : qwr_q + {3'h0, qwr_q != 4'hf};
			qflt_q <= (|fault_in || !live_in[0]) ? 4'h0 : qflt_q + {3'h0, qflt_q != 4'hf};
			qoff_q <= live_in[0] ? 4'h0 : qoff_q + {3'h0, qoff_q != 4'hf};
		end
	end

	a_alert_idle: assert property ($fell(rst) |-> alert0_n && alert1_n)
		else $error("alert low out of reset");
	a_oc_by_cmd: assert property ($changed(oc_resp) |-> qreq_q < 4'h8)
		else $error("oc response changed without a command");
	a_regs_by_cmd: assert property ($changed(ot_resp) || $changed(operation) |-> qreq_q < 4'h8)
		else $error("command register changed without a command");
	a_alert0_rise: assert property ($rose(alert0_n) |-> qreq_q < 4'h8 || qwr_q < 4'h8)
		else $error("alert 0 released without a clear");
	a_alert1_rise: assert property ($rose(alert1_n) |-> qreq_q < 4'h8 || qwr_q < 4'h8)
		else $error("alert 1 released without a clear");
	a_alert0_fall: assert property ($fell(alert0_n) |-> qreq_q < 4'h8 || qflt_q < 4'h8)
		else $error("alert 0 raised without cause");
	a_alert1_fall: assert property ($fell(alert1_n) |-> qreq_q < 4'h8 || qflt_q < 4'h8)
		else $error("alert 1 raised without cause");
	a_fault_both: assert property ($fell(alert0_n) && qreq_q > 4'h8 |-> !alert1_n)
		else $error("unit fault alerted one port only");
	a_shutdown_alert: assert property (qoff_q == 4'h8 |-> !alert0_n && !alert1_n)
		else $error("output off not alerted");
	a_wr_resp: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid &&
		s_axi_bresp == ((($past(s_axi_awaddr) & 8'he3) == 8'h00) ? `DPOS_RESP_OKAY : `DPOS_RESP_SLVERR))
		else $error("write response wrong");
	a_rd_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
		s_axi_rresp == ((($past(s_axi_araddr) & 8'he3) == 8'h00) ? `DPOS_RESP_OKAY : `DPOS_RESP_SLVERR))
		else $error("read response wrong");

	c_fault_both: cover property ($fell(alert0_n) && $fell(alert1_n));
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `DPOS_RESP_SLVERR);
	c_shutdown: cover property (qoff_q == 4'h8);
endmodule // dpos_props

bind dpos_top dpos_props #(.NLIVE(NLIVE), .NFIN(NFIN)) dpos_props_u (
	.clk, .rst, .p0_req, .p1_req, .fault_in, .live_in, .s_axi_wvalid, .s_axi_awvalid,
	.s_axi_awready, .s_axi_awaddr, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
	.alert0_n, .alert1_n, .oc_resp, .ot_resp, .operation, .s_axi_bvalid, .s_axi_bresp,
	.s_axi_rvalid, .s_axi_rresp
);

// file: dpos_host.sv
// Host controller model driving one serial command port
`timescale 1ns/1ps
module dpos_host (
	// Clock
	input  wire logic       clk,
	// Serial command lines
	output logic            scl,
	output logic            req,
	output logic      [2:0] kind,
	output logic      [7:0] data
);
	initial begin
		scl = 1'h0;
		req = 1'h0;
		kind = 3'h0;
		data = 8'h00;
	end

	// Serial clock stays low between frames; released lines show the inverse
	task automatic cmd(input logic [2:0] k, input logic [7:0] d);
		@(posedge clk);
		req  <= 1'h1;
		kind <= k;
		data <= d;
		repeat (4) @(posedge clk);
		scl <= 1'h1;
		repeat (4) @(posedge clk);
		scl  <= 1'h0;
		req  <= 1'h0;
		kind <= ~k;
		data <= ~d;
		repeat (8) @(posedge clk);
	endtask
endmodule // dpos_host

// file: testbench.sv
// Self-checking bench for the ownership and status block
`timescale 1ns/1ps
module testbench;
	logic        clk = 1'h0, rst = 1'h1, ce = 1'h1;
	logic        p0_scl, p0_req, p1_scl, p1_req, alert0_n, alert1_n;
	logic [2:0]  p0_kind, p1_kind;
	logic [7:0]  p0_data, p1_data, oc_resp, ot_resp, operation;
	logic [8:0]  fault_in = 9'h000;
	logic [3:0]  live_in = 4'h1, s_axi_wstrb = 4'h1;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'he95bf303;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [9:0]  lat = 10'h000;
	logic [7:0]  oc = 8'h00, ot = 8'h00, op = 8'h80;
	int          own = 0, cerr = 0, en = 1, miscompares = 0, n_tests = 0;
	int          fl[2] = '{0, 0};

	dpos_top dut_u (
		.clk, .rst, .ce, .p0_scl, .p0_req, .p0_kind, .p0_data, .p1_scl, .p1_req, .p1_kind,
		.p1_data, .fault_in, .live_in, .alert0_n, .alert1_n, .oc_resp, .ot_resp, .operation,
		.s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp
	);
	dpos_host host0_u (.clk, .scl(p0_scl), .req(p0_req), .kind(p0_kind), .data(p0_data));
	dpos_host host1_u (.clk, .scl(p1_scl), .req(p1_req), .kind(p1_kind), .data(p1_data));

	always #10 clk = ~clk;

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [9:0] cur();
		return {fault_in[8:7], !live_in[0], fault_in[6:0]};
	endfunction

	function automatic logic al(input int p);
		return (fl[p] != 0 && p != own) || cerr[p] || |(lat & 10'h2ff);
	endfunction

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		@(posedge clk);
		s_axi_awvalid <= 1'h1;
		s_axi_awaddr  <= a;
		s_axi_wvalid  <= 1'h1;
		s_axi_wdata   <= v;
		s_axi_bready  <= 1'h1;
		do @(posedge clk); while (!(s_axi_awready && s_axi_wready));
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid  <= 1'h0;
		do @(posedge clk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_arvalid <= 1'h1;
		s_axi_araddr  <= a;
		s_axi_rready  <= 1'h1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	task automatic check_all();
		logic [31:0] d;
		logic [1:0]  r;
		rd(8'h00, d, r);
		cmp("bus_status", {fl[1][2:0], own == 1, fl[0][2:0], own == 0}, d);
		rd(8'h04, d, r);
		cmp("status_word", {lat, cerr != 0, 1'h0}, d);
		rd(8'h08, d, r);
		cmp("status_cml", {cerr != 0, 7'h00}, d);
		rd(8'h0c, d, r);
		cmp("live_state", live_in, d);
		cmp("oc_resp", oc, oc_resp);
		cmp("ot_resp", ot, ot_resp);
		cmp("operation", op, operation);
		cmp("alert0_n", !al(0), alert0_n);
		cmp("alert1_n", !al(1), alert1_n);
	endtask

	task automatic pcmd(input int p, input int k, input logic [7:0] d);
		if (p == 0) host0_u.cmd(k[2:0], d);
		else host1_u.cmd(k[2:0], d);
		if (en == 0) begin
		end else if (k == 5) begin
			if (p != own) begin
				fl[p] = fl[p] | 3;
				fl[1 - p] = fl[1 - p] | 2;
				own = p;
			end
		end else if (k == 4) begin
			fl[p] = 0;
			cerr[p] = 1'b0;
			if (p == own) lat = cur();
		end else if (k != 0 && p != own) fl[p] = fl[p] | 6;
		else if (k >= 6) cerr[p] = 1'b1;
		else if (k == 1) oc = d;
		else if (k == 2) ot = d;
		else if (k == 3) op = d;
		check_all();
	endtask

	task automatic setf(input logic [8:0] f, input logic off);
		logic [31:0] v;
		v = rnd();
		@(posedge clk);
		fault_in <= f;
		live_in  <= {v[2:0], !off};
		repeat (8) @(posedge clk);
		lat = lat | cur();
		check_all();
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		int          i;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		check_all();
		pcmd(1, 1, 8'h3c);
		pcmd(1, 4, 8'h00);
		setf(9'h001, 1'h0);
		pcmd(1, 5, 8'h00);
		pcmd(1, 0, 8'h00);
		setf(9'h000, 1'h0);
		pcmd(1, 4, 8'h00);
		pcmd(0, 0, 8'h00);
		pcmd(0, 4, 8'h00);
		pcmd(0, 5, 8'h00);
		pcmd(0, 4, 8'h00);
		pcmd(1, 4, 8'h00);
		pcmd(1, 5, 8'h00);
		pcmd(1, 4, 8'h00);
		pcmd(0, 4, 8'h00);
		pcmd(0, 3, 8'h11);
		pcmd(0, 4, 8'h00);
		pcmd(1, 6, 8'h00);
		pcmd(1, 4, 8'h00);
		$display("test ownership done");
		for (i = 0; i < 24; i++) begin
			d = rnd();
			pcmd(d[8], i % 8, d[7:0]);
		end
		pcmd(own, 4, 8'h00);
		pcmd(1 - own, 4, 8'h00);
		$display("test commands done");
		for (i = 0; i < 10; i++) begin
			setf(9'h001 << i, i == 9);
			setf(9'h000, 1'h0);
			pcmd(own, 4, 8'h00);
		end
		setf(9'h002, 1'h0);
		pcmd(own, 4, 8'h00);
		setf(9'h000, 1'h0);
		pcmd(own, 4, 8'h00);
		$display("test latching done");
		wr(8'h20, 32'h0, r);
		cmp("bresp_unmapped", 2'h2, r);
		rd(8'h24, d, r);
		cmp("rresp_unmapped", 2'h2, r);
		cmp("rdata_unmapped", 32'h0, d);
		wr(8'h00, 32'hff, r);
		cmp("bresp_read_only", 2'h0, r);
		wr(8'h18, 32'h0, r);
		rd(8'h18, d, r);
		cmp("ctrl", 32'h0, d);
		en = 0;
		pcmd(1 - own, 1, 8'h77);
		wr(8'h18, 32'h1, r);
		en = 1;
		setf(9'h010, 1'h0);
		setf(9'h000, 1'h0);
		wr(8'h18, 32'h3, r);
		lat = cur();
		check_all();
		@(posedge clk);
		ce <= 1'h0;
		if (own == 0) host0_u.cmd(3'h1, 8'h5a);
		else host1_u.cmd(3'h1, 8'h5a);
		ce <= 1'h1;
		check_all();
		$display("test register bus done");
		end_of_test();
	end

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		end_of_test();
	end
endmodule // testbench
